/* verilog/mdc_pkg.sv */
package mdc_pkg;
  // byte register indices
  localparam logic [3:0] MDC_IDX_D_HIGH = 4'h7; // top operand byte, write starts operation
  localparam logic [3:0] MDC_IDX_MODE = 4'h8;
  localparam logic [3:0] MDC_IDX_FLAGS = 4'h9;
  localparam logic [3:0] MDC_IDX_IDENT = 4'hF;
  // mode byte fields
  localparam int MDC_MODE_SIGN_BIT = 4;
  localparam int MDC_MODE_EN_BIT = 7;
  localparam logic [7:0] MDC_MODE_WMASK = 8'h97; // writable mode bits
  // flags byte fields (bit positions within the flags byte)
  localparam int MDC_FLG_BUSY_BIT = 0;  // word bit 8
  localparam int MDC_FLG_SAT_BIT = 3;   // word bit 11
  localparam int MDC_FLG_OVF_BIT = 4;   // word bit 12
  localparam int MDC_FLG_NEG_BIT = 5;   // word bit 13
  localparam int MDC_FLG_ZERO_BIT = 6;  // word bit 14
  localparam int MDC_FLG_CARRY_BIT = 7; // word bit 15
  localparam logic [7:0] MDC_FLAGS_WMASK = 8'hF8; // software-writable flag bits
  // operation codes
  localparam logic [2:0] MDC_OP_MUL = 3'h0;
  localparam logic [2:0] MDC_OP_DIV16 = 3'h1;
  localparam logic [2:0] MDC_OP_MAC = 3'h2;
  localparam logic [2:0] MDC_OP_MACS = 3'h3;
  localparam logic [2:0] MDC_OP_DIV32 = 3'h5;
  // operation lengths in cycles
  localparam logic [4:0] MDC_CYC_MUL = 5'h04;
  localparam logic [4:0] MDC_CYC_DIV16 = 5'h08;
  localparam logic [4:0] MDC_CYC_DIV32 = 5'h10;
  // saturation limits
  localparam logic [31:0] MDC_SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] MDC_SAT_NEG = 32'h8000_0000;
  localparam logic [7:0] MDC_ZERO_BYTE = 8'h00;
  localparam logic [7:0] MDC_ID_DEFAULT = 8'h5A; // arbitrary identity value
  typedef enum logic [0:0] {MDC_IDLE, MDC_RUN} mdc_state_type;
endpackage

/* verilog/mdc_coproc.sv */
`timescale 1ns/1ps
// Function
// - write to top D byte starts operation
// - select field chooses operation, others idle
// - sign bit four picks unsigned or signed
// - signed mode uses two's complement msb
// - enable clear lets running operation finish
// - busy bit eight high while running
// - multiply uses D, C, addend AB
// - divide uses AB dividend, D/CD divisor
// - untouched operand registers keep their value
// - saturating accumulate clamps to signed limits
// - carry on carry or zero divisor
// - zero flag follows result; negative flag only for accumulates and signed multiply/divide
// - overflow flag; flags other than busy writable by software
// - saturation flag sticky until written zero
// - flag update depends on mode, sign
// - bytes ten to fourteen read zero
// - byte fifteen returns constant identity
// - wider views from consecutive bytes, little-endian
// - operands and mode/status reset to zero
// - four, eight, sixteen cycle operation times
module mdc_coproc import mdc_pkg::*; #(
  parameter logic [7:0] ID_VALUE = MDC_ID_DEFAULT // arbitrary identity value
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,     // byte register index of lowest byte
  input wire logic [7:0] i_wr_be,    // per-byte write strobes from i_addr upward
  input wire logic [63:0] i_wr_data, // lowest byte in bits 7:0
  output logic [63:0] o_rd_data,     // bytes from i_addr upward, registered
  output logic o_busy
);
  // byte file for operands and mode/flags
  logic [7:0] regs_ff [0:9];
  logic [7:0] nxt_regs [0:9];
  mdc_state_type state_ff;           // run state
  logic [4:0] cnt_ff;                // remaining cycles
  logic [2:0] op_ff;                 // latched operation
  logic sgn_ff;                      // latched signedness
  logic [63:0] rd_ff;                // registered read data
  logic busy_ff;

  // byte lookup with unused and identity bytes
  function automatic logic [7:0] rd_byte(input logic [3:0] idx, input logic [7:0] r [0:9], input logic [7:0] idv);
    logic [7:0] v;
    v = MDC_ZERO_BYTE;
    if (idx == MDC_IDX_IDENT) begin
      v = idv;
    end else if (idx <= MDC_IDX_FLAGS) begin
      v = r[idx];
    end
    return v;
  endfunction

  // operand words
  wire [15:0] a_w = {regs_ff[1], regs_ff[0]};
  wire [15:0] b_w = {regs_ff[3], regs_ff[2]};
  wire [15:0] c_w = {regs_ff[5], regs_ff[4]};
  wire [15:0] d_w = {regs_ff[7], regs_ff[6]};
  wire [31:0] ab_w = {b_w, a_w};
  wire [31:0] cd_w = {d_w, c_w};
  wire [7:0] mode_w = regs_ff[MDC_IDX_MODE];
  wire [7:0] flg_w = regs_ff[MDC_IDX_FLAGS];
  wire enable_w = mode_w[MDC_MODE_EN_BIT];
  wire sign_w = mode_w[MDC_MODE_SIGN_BIT];
  wire [2:0] opsel_w = mode_w[2:0];

  // top D byte write detection across views
  logic [3:0] d_hi_off;
  assign d_hi_off = MDC_IDX_D_HIGH - i_addr;
  wire d_hi_wr = (i_addr <= MDC_IDX_D_HIGH) && i_wr_be[d_hi_off[2:0]] && (d_hi_off < 4'h8);
  wire op_valid = (opsel_w == MDC_OP_MUL) || (opsel_w == MDC_OP_DIV16) || (opsel_w == MDC_OP_MAC) ||
                  (opsel_w == MDC_OP_MACS) || (opsel_w == MDC_OP_DIV32);
  wire start_w = (state_ff == MDC_IDLE) && d_hi_wr && enable_w && op_valid;
  wire [4:0] start_len = (opsel_w == MDC_OP_DIV16) ? MDC_CYC_DIV16 :
                         (opsel_w == MDC_OP_DIV32) ? MDC_CYC_DIV32 : MDC_CYC_MUL;
  wire done_w = (state_ff == MDC_RUN) && (cnt_ff == 5'h01);

  // arithmetic: sign-extended multiply, accumulate
  // both operands widened so the signed product cannot wrap
  wire signed [33:0] mul_s = $signed({{18{sgn_ff & d_w[15]}}, d_w}) * $signed({{18{sgn_ff & c_w[15]}}, c_w});
  wire [31:0] prod = mul_s[31:0];
  wire signed [33:0] acc_s = mul_s + $signed({{2{sgn_ff & ab_w[31]}}, ab_w});
  wire [32:0] acc_u = {1'b0, prod} + {1'b0, ab_w};
  wire [31:0] acc = acc_s[31:0];
  wire acc_ovf = sgn_ff ? (acc_s[33:31] != {3{acc_s[31]}}) : acc_u[32];
  wire acc_carry = acc_u[32];
  wire pos_sat = sgn_ff ? !acc_s[33] : 1'b1;
  wire [31:0] sat_val = pos_sat ? MDC_SAT_POS : MDC_SAT_NEG;
  wire do_sat = (op_ff == MDC_OP_MACS) && acc_ovf;
  wire [31:0] mac_res = do_sat ? sat_val : acc;

  // division with magnitudes, signs restored
  wire is_div32 = (op_ff == MDC_OP_DIV32);
  wire [31:0] dvsr = is_div32 ? cd_w : {{16{sgn_ff & d_w[15]}}, d_w};
  wire dvnd_neg = sgn_ff & ab_w[31];
  wire dvsr_neg = sgn_ff & dvsr[31];
  wire [31:0] dvnd_mag = dvnd_neg ? (32'h0000_0000 - ab_w) : ab_w;
  wire [31:0] dvsr_mag = dvsr_neg ? (32'h0000_0000 - dvsr) : dvsr;
  wire div_zero = (dvsr == 32'h0000_0000);
  wire [31:0] q_mag = div_zero ? 32'hFFFF_FFFF : (dvnd_mag / dvsr_mag);
  wire [31:0] r_mag = div_zero ? dvnd_mag : (dvnd_mag % dvsr_mag);
  wire [31:0] quot = (dvnd_neg ^ dvsr_neg) ? (32'h0000_0000 - q_mag) : q_mag;
  wire [31:0] remd = dvnd_neg ? (32'h0000_0000 - r_mag) : r_mag;
  wire div_ovf = sgn_ff && dvnd_neg && (ab_w == MDC_SAT_NEG) && (dvsr == 32'hFFFF_FFFF);

  // result selection
  wire is_mac = (op_ff == MDC_OP_MAC) || (op_ff == MDC_OP_MACS);
  wire is_div = (op_ff == MDC_OP_DIV16) || is_div32;
  wire [31:0] res = is_mac ? mac_res : (is_div ? quot : prod);
  wire res_carry = is_div ? div_zero : (is_mac ? acc_carry : 1'b0);
  wire upd_ns = is_mac || (is_div && sgn_ff) || ((op_ff == MDC_OP_MUL) && sgn_ff);
  wire upd_ov = is_mac || (is_div && sgn_ff);
  wire upd_c = is_mac || is_div;

  // new flags byte at writeback
  logic [7:0] done_flags;
  always_comb begin
    done_flags = flg_w;
    if (upd_c) begin
      done_flags[MDC_FLG_CARRY_BIT] = res_carry;
    end
    done_flags[MDC_FLG_ZERO_BIT] = (res == 32'h0000_0000);
    if (upd_ns) begin
      done_flags[MDC_FLG_NEG_BIT] = res[31];
    end
    if (upd_ov) begin
      done_flags[MDC_FLG_OVF_BIT] = is_mac ? acc_ovf : div_ovf;
    end
    if (op_ff == MDC_OP_MACS) begin
      done_flags[MDC_FLG_SAT_BIT] = flg_w[MDC_FLG_SAT_BIT] | do_sat;
    end
    done_flags[MDC_FLG_BUSY_BIT] = 1'b0;
  end

  // next byte file: software writes, then writeback wins
  always_comb begin
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 10; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    for (int k = 0; k < 8; k++) begin
      idx = i_addr + k[3:0];
      if (i_wr_be[k] && (idx <= MDC_IDX_FLAGS) && ({1'b0, i_addr} + k[4:0] <= {1'b0, MDC_IDX_FLAGS})) begin
        if (idx == MDC_IDX_MODE) begin
          nxt_regs[idx] = i_wr_data[k*8 +: 8] & MDC_MODE_WMASK;
        end else if (idx == MDC_IDX_FLAGS) begin
          nxt_regs[idx] = (i_wr_data[k*8 +: 8] & MDC_FLAGS_WMASK) | (flg_w & ~MDC_FLAGS_WMASK);
        end else begin
          nxt_regs[idx] = i_wr_data[k*8 +: 8]; // operand bytes
        end
      end
    end
    if (start_w) begin
      nxt_regs[MDC_IDX_FLAGS][MDC_FLG_BUSY_BIT] = 1'b1;
    end
    if (done_w) begin
      nxt_regs[MDC_IDX_FLAGS] = done_flags;
      {nxt_regs[3], nxt_regs[2], nxt_regs[1], nxt_regs[0]} = res;
      if (op_ff == MDC_OP_DIV16) begin
        {nxt_regs[5], nxt_regs[4]} = remd[15:0];
      end else if (is_div32) begin
        {nxt_regs[7], nxt_regs[6], nxt_regs[5], nxt_regs[4]} = remd;
      end
    end
  end

  // read data assembled from consecutive bytes
  logic [63:0] nxt_rd;
  always_comb begin
    nxt_rd = 64'h0;
    for (int k = 0; k < 8; k++) begin
      if ({1'b0, i_addr} + k[4:0] <= 5'h0F) begin
        nxt_rd[k*8 +: 8] = rd_byte(i_addr + k[3:0], regs_ff, ID_VALUE);
      end
    end
  end

  // byte file register
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 10; i++) begin
        regs_ff[i] <= MDC_ZERO_BYTE;
      end
    end else begin
      for (int i = 0; i < 10; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // sequencer
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= MDC_IDLE;
      cnt_ff <= 5'h00;
      op_ff <= MDC_OP_MUL;
      sgn_ff <= 1'b0;
    end else begin
      case (state_ff)
        MDC_IDLE: begin
          if (start_w) begin
            state_ff <= MDC_RUN;
            cnt_ff <= start_len;
            op_ff <= opsel_w;
            sgn_ff <= sign_w;
          end
        end
        MDC_RUN: begin
          cnt_ff <= cnt_ff - 5'h01;
          if (done_w) begin
            state_ff <= MDC_IDLE;
          end
        end
        default: state_ff <= MDC_IDLE;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_ff <= 64'h0;
      busy_ff <= 1'b0;
    end else begin
      rd_ff <= nxt_rd;
      busy_ff <= nxt_regs[MDC_IDX_FLAGS][MDC_FLG_BUSY_BIT];
    end
  end
  // outputs straight from the flops
  assign o_rd_data = rd_ff;
  assign o_busy = busy_ff;

  // checks
  property p_busy_rise;
    @(posedge i_sys_clk) disable iff (!i_reset_n) start_w |=> flg_w[MDC_FLG_BUSY_BIT];
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise after start");
  property p_mul_len;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (start_w && opsel_w == MDC_OP_MUL) |=> flg_w[MDC_FLG_BUSY_BIT] [*4] ##1 !flg_w[MDC_FLG_BUSY_BIT];
  endproperty
  a_mul_len: assert property (p_mul_len) else $error("multiply length wrong");
  property p_div16_len;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (start_w && opsel_w == MDC_OP_DIV16) |=> flg_w[MDC_FLG_BUSY_BIT] [*8] ##1 !flg_w[MDC_FLG_BUSY_BIT];
  endproperty
  a_div16_len: assert property (p_div16_len) else $error("short divide length wrong");
  property p_div32_len;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (start_w && opsel_w == MDC_OP_DIV32) |=> ##15 flg_w[MDC_FLG_BUSY_BIT] ##1 !flg_w[MDC_FLG_BUSY_BIT];
  endproperty
  a_div32_len: assert property (p_div32_len) else $error("long divide length wrong");
  property p_no_start_disabled;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_ff == MDC_IDLE && d_hi_wr && !enable_w) |=> !flg_w[MDC_FLG_BUSY_BIT];
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled) else $error("started while disabled");
  property p_sat_clamp;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (done_w && do_sat) |=> (ab_w == MDC_SAT_POS || ab_w == MDC_SAT_NEG) && flg_w[MDC_FLG_SAT_BIT];
  endproperty
  a_sat_clamp: assert property (p_sat_clamp) else $error("saturation clamp missing");
  property p_mul_keeps_c;
    @(posedge i_sys_clk) disable iff (!i_reset_n) (done_w && !is_div) |=> $stable(c_w) && $stable(d_w);
  endproperty
  a_mul_keeps_c: assert property (p_mul_keeps_c) else $error("operand changed by multiply");
  property p_zero_div_carry;
    @(posedge i_sys_clk) disable iff (!i_reset_n) (done_w && is_div && div_zero) |=> flg_w[MDC_FLG_CARRY_BIT];
  endproperty
  a_zero_div_carry: assert property (p_zero_div_carry) else $error("zero divisor carry missing");
  property p_zero_flag;
    @(posedge i_sys_clk) disable iff (!i_reset_n) done_w |=> (flg_w[MDC_FLG_ZERO_BIT] == (ab_w == 32'h0000_0000));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");
  property p_sat_sticky;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (flg_w[MDC_FLG_SAT_BIT] && !(|i_wr_be)) |=> flg_w[MDC_FLG_SAT_BIT];
  endproperty
  a_sat_sticky: assert property (p_sat_sticky) else $error("saturation flag dropped");
  // unused bytes read zero in the wide view
  property p_rsvd_read_zero;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_addr == MDC_IDX_MODE) |=> (o_rd_data[55:16] == 40'h00_0000_0000);
  endproperty
  a_rsvd_read_zero: assert property (p_rsvd_read_zero) else $error("unused byte not zero");
  // identity byte in the top lane
  property p_ident_read;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_addr == MDC_IDX_MODE) |=> (o_rd_data[63:56] == ID_VALUE);
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("identity byte wrong");
  // empty select codes never start
  property p_noop_code;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_ff == MDC_IDLE && d_hi_wr && enable_w && opsel_w[2] && opsel_w != MDC_OP_DIV32) |=> !o_busy;
  endproperty
  a_noop_code: assert property (p_noop_code) else $error("empty code started");
  // multiply leaves carry and overflow alone
  property p_mul_keeps_flags;
    @(posedge i_sys_clk) disable iff (!i_reset_n) (done_w && op_ff == MDC_OP_MUL) |=>
      (flg_w[MDC_FLG_CARRY_BIT] == $past(flg_w[MDC_FLG_CARRY_BIT])) && (flg_w[MDC_FLG_OVF_BIT] == $past(flg_w[MDC_FLG_OVF_BIT]));
  endproperty
  a_mul_keeps_flags: assert property (p_mul_keeps_flags) else $error("multiply changed carry");
  // saturation flag untouched outside saturating accumulate
  property p_sat_only_macs;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (done_w && op_ff != MDC_OP_MACS) |=> (flg_w[MDC_FLG_SAT_BIT] == $past(flg_w[MDC_FLG_SAT_BIT]));
  endproperty
  a_sat_only_macs: assert property (p_sat_only_macs) else $error("saturation flag changed");
  // negative flag follows result top bit
  property p_neg_flag;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (done_w && (is_mac || sgn_ff)) |=> (flg_w[MDC_FLG_NEG_BIT] == ab_w[31]);
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");
  // short divide keeps the divisor word
  property p_div16_keeps_d;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (done_w && op_ff == MDC_OP_DIV16) |=> $stable(d_w);
  endproperty
  a_div16_keeps_d: assert property (p_div16_keeps_d) else $error("divisor changed by divide");
  // operation and sign latched at start
  property p_start_latch;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      start_w |=> (op_ff == $past(opsel_w)) && (sgn_ff == $past(sign_w));
  endproperty
  a_start_latch: assert property (p_start_latch) else $error("operation not latched");
  // busy bit and pin drop at writeback
  property p_busy_clear;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      done_w |=> !flg_w[MDC_FLG_BUSY_BIT] && !o_busy;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");
  // a run with enable cleared still completes
  property p_enable_finish;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_ff == MDC_RUN && !enable_w) |-> ##[0:16] done_w;
  endproperty
  a_enable_finish: assert property (p_enable_finish) else $error("disabled run did not finish");
endmodule

/* tb/mdc_cpu_model.sv */
`timescale 1ns/1ps
// cpu side: byte-lane transfers into the coprocessor registers
module mdc_cpu_model (
  input wire logic i_sys_clk,
  input wire logic [63:0] i_rd_data,
  output logic [3:0] o_addr,
  output logic [7:0] o_wr_be,
  output logic [63:0] o_wr_data
);
  // idle bus from time zero
  initial begin
    o_addr = 4'h0;
    o_wr_be = 8'h00;
    o_wr_data = 64'hA5A5_A5A5_A5A5_A5A5;
  end
  // one write, data lines scrambled once released
  task automatic wr(input logic [3:0] a, input logic [7:0] be, input logic [63:0] d);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    o_wr_be = be;
    o_wr_data = d;
    @(posedge i_sys_clk);
    #1;
    o_wr_be = 8'h00;
    o_wr_data = ~d;
  endtask
  // one read, data taken one edge after the address
  task automatic rd(input logic [3:0] a, output logic [63:0] q);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    @(posedge i_sys_clk);
    #1;
    q = i_rd_data;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import mdc_pkg::*;;
  localparam logic [7:0] TB_ID = 8'h3C; // arbitrary identity value
  logic i_sys_clk;
  logic i_reset_n;
  logic [3:0] addr;
  logic [7:0] wr_be;
  logic [63:0] wr_data;
  logic [63:0] rd_data;
  logic busy;
  logic [63:0] q; // last read value
  int n_mismatch = 0;
  int n_compared = 0;
  int busy_cnt = 0; // busy cycles since time zero
  int busy_base = 0; // busy count when the current run began
  // 40 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  mdc_coproc #(.ID_VALUE(TB_ID)) DUT (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(addr),
    .i_wr_be(wr_be), .i_wr_data(wr_data), .o_rd_data(rd_data), .o_busy(busy));
  mdc_cpu_model cpu (.i_sys_clk(i_sys_clk), .i_rd_data(rd_data), .o_addr(addr), .o_wr_be(wr_be),
    .o_wr_data(wr_data));
  // count edges with busy high
  always @(posedge i_sys_clk) begin
    if (busy === 1'b1) begin
      busy_cnt++;
    end
  end
  // value compare
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // busy length compare after the run has settled
  task automatic cmp_cnt(input int exp);
    repeat (20) @(posedge i_sys_clk);
    #1;
    n_compared++;
    if (busy_cnt - busy_base != exp) begin
      n_mismatch++;
      $display("unexpected busy at %0t: got %h exp %h", $time, busy_cnt - busy_base, exp);
    end
  endtask
  // program mode and flags, load all eight operand bytes in one write, check busy length, result bytes, mode and masked flags
  task automatic run(input logic [7:0] mode, input logic [7:0] fl, input logic [63:0] ops,
      input logic [63:0] exp, input logic [7:0] efl, input logic [7:0] msk, input int cyc);
    cpu.wr(MDC_IDX_MODE, 8'h03, {48'h0, fl, mode});
    busy_base = busy_cnt;
    cpu.wr(4'h0, 8'hFF, ops);
    cmp_cnt(cyc);
    cpu.rd(4'h0, q);
    cmp(q, exp);
    cpu.rd(MDC_IDX_MODE, q);
    cmp({48'h0, q[15:8] & msk, q[7:0]}, {48'h0, efl & msk, mode});
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #(3000 * 25);
    n_mismatch++;
    test_done();
  end
  // main sequence
  initial begin
    i_reset_n = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    cpu.rd(4'h0, q);
    cmp(q, 64'h0);
    cpu.rd(MDC_IDX_MODE, q);
    cmp(q, {TB_ID, 56'h0});
    cpu.wr(MDC_IDX_MODE, 8'hFC, '1); // unused and identity bytes only
    cpu.rd(MDC_IDX_MODE, q);
    cmp(q, {TB_ID, 56'h0});
    // disabled, then the three empty select codes
    run(8'h00, 8'h00, 64'h3_0005_0000_0007, 64'h3_0005_0000_0007, 8'h00, 8'hF9, 0);
    for (int k = 4; k < 8; k++) begin
      if (k != 5) begin
        run({5'h10, k[2:0]}, 8'h00, 64'h3_0005_0000_0007, 64'h3_0005_0000_0007, 8'h00, 8'hF9, 0);
      end
    end
    // multiply, divides and accumulates
    run(8'h80, 8'hF8, 64'hFFFF_0002_1111_2222, 64'hFFFF_0002_0001_FFFE, 8'hB8, 8'hF9, 4);
    run(8'h90, 8'h00, 64'hFFFF_0002_0000_0000, 64'hFFFF_0002_FFFF_FFFE, 8'h20, 8'hF9, 4);
    run(8'h81, 8'h40, 64'h0000_1234_0000_0064, 64'h0000_0064_FFFF_FFFF, 8'h80, 8'hF9, 8);
    run(8'h81, 8'h00, 64'h0007_AAAA_0000_0005, 64'h0007_0005_0000_0000, 8'h40, 8'hF9, 8);
    run(8'h95, 8'h00, 64'h0000_0007_FFFF_FF9C, 64'hFFFF_FFFE_FFFF_FFF2, 8'h20, 8'hF9, 16);
    run(8'h83, 8'h00, 64'hFFFF_FFFF_0002_0000, 64'hFFFF_FFFF_7FFF_FFFF, 8'h98, 8'hF9, 4);
    run(8'h93, 8'h00, 64'h8000_7FFF_8000_0000, 64'h8000_7FFF_8000_0000, 8'h38, 8'h59, 4);
    run(8'h82, 8'h08, 64'hFFFF_FFFF_0002_0000, 64'hFFFF_FFFF_0000_0001, 8'h98, 8'hF9, 4);
    // enable cleared mid-run: divide completes, next start refused
    cpu.wr(MDC_IDX_MODE, 8'h01, 64'h85);
    busy_base = busy_cnt;
    cpu.wr(MDC_IDX_D_HIGH, 8'h01, 64'hFF);
    cpu.wr(MDC_IDX_MODE, 8'h01, 64'h05);
    cpu.rd(MDC_IDX_FLAGS, q);
    cmp({63'h0, q[0]}, 64'h1);
    cmp_cnt(16);
    busy_base = busy_cnt;
    cpu.wr(MDC_IDX_D_HIGH, 8'h01, 64'hFF);
    cmp_cnt(0);
    test_done();
  end
endmodule
